//--- test/radio_aux_control_regs_sva.sv
// Port-level assertions for the auxiliary register bank.
`include "radio_aux_consts.svh"
`timescale 1ns/1ns
module radio_aux_control_regs_sva #(
    parameter int CAL_W = 8
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [11:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [31:0]                 prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [CAL_W-1:0]            auto_cal_result,
    input wire logic [CAL_W-1:0]            user_cal_result,
    input wire logic [CAL_W-1:0]            cal_result,
    input wire aux_types_pkg::cal_source_t  cal_source,
    input wire logic                        cal_source_clk,
    input wire logic                        chip_select,
    input wire logic                        shutdown_start,
    input wire logic                        chip_active,
    input wire aux_types_pkg::rx_chain_en_t rx_chain,
    input wire logic                        temp_monitor_on,
    input wire logic                        supply_monitor_on,
    input wire logic [7:0]                  adc_result_in,
    input wire logic                        adc_result_valid,
    input wire logic [12:0]                 supply_level_mv,
    input wire logic                        supply_level_valid,
    input wire logic                        battery_alarm,
    input wire logic                        clock_out_pin,
    input wire logic                        clock_out_enable
);
    // ======================================================================
    // Decode
    wire       acc = psel && penable;
    wire       wr  = acc && pwrite;
    wire [9:0] idx = paddr[11:2];
    wire       clr = wr && idx == `IDX_INTERRUPT_SOURCE_1 && pwdata[7];
    wire       hit = idx inside {`IDX_IMAGE_REJECT_CAL_SETUP, `IDX_CHIP_SHUTDOWN_REQUEST, `IDX_RECEIVE_CHAIN_POWER,
                     `IDX_MONITOR_POWER, `IDX_CONVERTER_RESULT_HIGH, `IDX_CONVERTER_RESULT_LOW,
                     `IDX_SUPPLY_ALARM_THRESHOLD, `IDX_CLOCK_OUT_DIVIDER, `IDX_INTERRUPT_SOURCE_1};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ======================================================================
    // Assertions
    unmapped_error_a: assert property (acc && !hit |-> pready && pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && hit |-> pready && !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access answered wrongly");
    shutdown_gate_a: assert property (!$past(chip_select) |-> !shutdown_start)
        else $error("shutdown started without chip select");
    active_state_a: assert property (wr && idx == `IDX_CHIP_SHUTDOWN_REQUEST && !pwdata[0] |-> ##2
        chip_active)
        else $error("chip not active after request cleared");
    cal_fields_a: assert property (wr && idx == `IDX_IMAGE_REJECT_CAL_SETUP |-> ##3
        cal_source.freq_sel == $past(pwdata[4:3], 3) && cal_source.power_sel == $past(pwdata[2:0], 3))
        else $error("calibration source fields not taken");
    level_map_a: assert property (cal_source.level == 3'(({1'b0, cal_source.power_sel} + 4'h1) >> 1))
        else $error("power level mapping wrong");
    rx_enables_a: assert property (wr && idx == `IDX_RECEIVE_CHAIN_POWER |-> ##3
        rx_chain == $past(pwdata[4:0], 3))
        else $error("receive enables not taken");
    monitor_en_a: assert property (wr && idx == `IDX_MONITOR_POWER |-> ##3
        {temp_monitor_on, supply_monitor_on} == $past(pwdata[1:0], 3))
        else $error("monitor enables not taken");
    divider_en_a: assert property (wr && idx == `IDX_CLOCK_OUT_DIVIDER |-> ##3
        clock_out_enable == ($past(pwdata[3:0], 3) != 4'h0))
        else $error("clock output enable wrong");
    clock_off_a: assert property (!clock_out_enable && !$past(clock_out_enable) |-> !clock_out_pin)
        else $error("clock output toggles while disabled");
    alarm_cause_a: assert property ($rose(battery_alarm) |-> $past(supply_level_valid, 2))
        else $error("alarm raised without a sample");
    alarm_hold_a: assert property (battery_alarm && !clr && !$past(clr) |=> battery_alarm)
        else $error("alarm dropped without a clear");
endmodule
bind radio_aux_control_regs radio_aux_control_regs_sva #(.CAL_W(CAL_W)) radio_aux_control_regs_sva_inst (.*);

//--- test/tb.sv
// Self-checking bench for the auxiliary register bank.
`include "radio_aux_consts.svh"
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic        chip_select = 1'b0, adc_result_valid = 1'b0, supply_level_valid = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  auto_cal_result = 8'h00, user_cal_result = 8'h00, cal_result, adc_result_in = 8'h00, v;
    logic [12:0] supply_level_mv = 13'h0000;
    logic        cal_source_clk, shutdown_start, chip_active, temp_monitor_on, supply_monitor_on;
    logic        battery_alarm, clock_out_pin, clock_out_enable;
    aux_types_pkg::cal_source_t  cal_source;
    aux_types_pkg::rx_chain_en_t rx_chain;
    int          err_count = 0, checks = 0, p, t;
    int          dv [6] = '{0, 2, 3, 5, 8, 15};
    logic [7:0]  mdl [int];
    logic [7:0]  msk [int];
    radio_aux_control_regs radio_aux_control_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .auto_cal_result, .user_cal_result, .cal_result, .cal_source, .cal_source_clk,
        .chip_select, .shutdown_start, .chip_active, .rx_chain, .temp_monitor_on, .supply_monitor_on, .adc_result_in,
        .adc_result_valid, .supply_level_mv, .supply_level_valid, .battery_alarm, .clock_out_pin, .clock_out_enable);
    // ======================================================================
    // Tasks
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // The request is held until pready is seen high; only the watchdog ends a stalled wait.
    task automatic xfer(input logic [9:0] i, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= {i, 2'b00};
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && msk.exists(i)) mdl[i] = d[7:0] & msk[i];
        if (w && i == `IDX_INTERRUPT_SOURCE_1 && d[7]) mdl[i] = 8'h00;
    endtask
    task automatic rchk(input logic [9:0] i);
        xfer(i, 1'b0, 32'h0);
        `CHK(rd, {24'h0, mdl.exists(i) ? mdl[i] : 8'h00})
        `CHK(er, !mdl.exists(i))
    endtask
    task automatic sample(input int mv);
        supply_level_mv <= 13'(mv);
        supply_level_valid <= 1'b1;
        @(posedge pclk);
        supply_level_valid <= 1'b0;
        tk(3);
    endtask
    // Period in cycles between two rising edges of the chosen clock output.
    task automatic per(input bit s, output int q);
        int n;
        logic pv, cv;
        q = 0;
        n = 0;
        pv = 1'b1;
        repeat (70)
        begin
            @(posedge pclk);
            cv = s ? clock_out_pin : cal_source_clk;
            if (n > 0) n++;
            if (cv && !pv && n > 0 && q == 0) q = n - 1;
            if (cv && !pv) n = 1;
            pv = cv;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ======================================================================
    // Clock, watchdog and sequence
    initial forever #10 pclk = ~pclk;
    initial
    begin
        repeat (30000) @(posedge pclk);
        err_count++;
        close_out();
    end
    initial
    begin
        mdl = '{`IDX_IMAGE_REJECT_CAL_SETUP: 8'h00, `IDX_CHIP_SHUTDOWN_REQUEST: 8'h00, `IDX_RECEIVE_CHAIN_POWER: 8'h00,
                `IDX_MONITOR_POWER: 8'h00, `IDX_CONVERTER_RESULT_HIGH: 8'h00, `IDX_CONVERTER_RESULT_LOW: 8'h00,
                `IDX_SUPPLY_ALARM_THRESHOLD: 8'h00, `IDX_CLOCK_OUT_DIVIDER: 8'h04, `IDX_INTERRUPT_SOURCE_1: 8'h00};
        msk = '{`IDX_IMAGE_REJECT_CAL_SETUP: 8'h3f, `IDX_CHIP_SHUTDOWN_REQUEST: 8'h01, `IDX_RECEIVE_CHAIN_POWER: 8'h1f,
                `IDX_MONITOR_POWER: 8'h03, `IDX_SUPPLY_ALARM_THRESHOLD: 8'h1f, `IDX_CLOCK_OUT_DIVIDER: 8'h0f};
        void'($urandom(35819));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (mdl[i]) rchk(10'(i));
        rchk(10'h000);
        `CHK(chip_active, 1'b1)
        $display("reset and map test done");
        repeat (16)
        begin
            foreach (msk[i]) xfer(10'(i), 1'b1, $urandom & 32'(msk[i]));
            foreach (mdl[i]) rchk(10'(i));
            tk(3);
            `CHK(rx_chain, mdl[`IDX_RECEIVE_CHAIN_POWER][4:0])
            `CHK({temp_monitor_on, supply_monitor_on}, mdl[`IDX_MONITOR_POWER][1:0])
        end
        $display("enable test done");
        for (int k = 0; k < 64; k++)
        begin
            v = 8'(k);
            auto_cal_result <= 8'($urandom);
            user_cal_result <= 8'($urandom);
            xfer(`IDX_IMAGE_REJECT_CAL_SETUP, 1'b1, 32'(v));
            tk(3);
            `CHK(cal_source, {v[4:0], v[4:3] != 2'h0 && v[2:0] != 3'h0, 3'((v[2:0] + 4'h1) >> 1)})
            `CHK(cal_result, v[5] ? user_cal_result : auto_cal_result)
        end
        for (int f = 1; f < 4; f++)
        begin
            xfer(`IDX_IMAGE_REJECT_CAL_SETUP, 1'b1, 32'(f * 8 + 1));
            per(1'b0, p);
            `CHK(p, 2 << f)
        end
        $display("calibration test done");
        xfer(`IDX_CHIP_SHUTDOWN_REQUEST, 1'b1, 32'h1);
        tk(3);
        `CHK({shutdown_start, chip_active}, 2'b01)
        chip_select <= 1'b1;
        tk(3);
        `CHK({shutdown_start, chip_active}, 2'b10)
        xfer(`IDX_CHIP_SHUTDOWN_REQUEST, 1'b1, 32'h0);
        tk(3);
        `CHK({shutdown_start, chip_active}, 2'b01)
        $display("shutdown test done");
        repeat (4)
        begin
            v = 8'($urandom);
            adc_result_in <= v;
            adc_result_valid <= 1'b1;
            @(posedge pclk);
            adc_result_valid <= 1'b0;
            mdl[`IDX_CONVERTER_RESULT_HIGH] = {2'b00, v[7:2]};
            mdl[`IDX_CONVERTER_RESULT_LOW] = {v[1:0], 6'h00};
            xfer(`IDX_CONVERTER_RESULT_HIGH, 1'b1, 32'h3f);
            rchk(`IDX_CONVERTER_RESULT_HIGH);
            rchk(`IDX_CONVERTER_RESULT_LOW);
        end
        $display("converter test done");
        for (int k = 0; k < 3; k++)
        begin
            v = k == 0 ? 8'h00 : k == 1 ? 8'h1f : 8'($urandom % 32);
            xfer(`IDX_MONITOR_POWER, 1'b1, 32'h1);
            xfer(`IDX_SUPPLY_ALARM_THRESHOLD, 1'b1, 32'(v));
            t = 1700 + 62 * (v + 1);
            sample(t);
            `CHK(battery_alarm, 1'b0)
            sample(t - 1);
            `CHK(battery_alarm, 1'b1)
            mdl[`IDX_INTERRUPT_SOURCE_1] = 8'h80;
            rchk(`IDX_INTERRUPT_SOURCE_1);
            xfer(`IDX_INTERRUPT_SOURCE_1, 1'b1, 32'h80);
            rchk(`IDX_INTERRUPT_SOURCE_1);
            xfer(`IDX_MONITOR_POWER, 1'b1, 32'h0);
            sample(1000);
            `CHK(battery_alarm, 1'b0)
        end
        $display("alarm test done");
        foreach (dv[j])
        begin
            t = dv[j];
            xfer(`IDX_CLOCK_OUT_DIVIDER, 1'b1, 32'(t));
            tk(3);
            `CHK(clock_out_enable, t != 0)
            per(1'b1, p);
            `CHK(p, t)
        end
        $display("clock output test done");
        close_out();
    end
endmodule

//--- verilog/aux_types_pkg.sv
// Packed carrier types of the auxiliary register bank.
package aux_types_pkg;

    typedef struct packed {
        logic converter_on;
        logic signal_strength_on;
        logic if_filter_on;
        logic mixer_on;
        logic low_noise_amp_on;
    } rx_chain_en_t;

    typedef struct packed {
        logic [1:0] freq_sel;
        logic [2:0] power_sel;
        logic       source_on;
        logic [2:0] level;
    } cal_source_t;

endpackage

//--- verilog/radio_aux_consts.svh
// Register indices, field positions, reset values and supply trip figures of the auxiliary register bank.
// Functional notes
// - Override bit set: use software calibration results instead of automatic ones.
// - Source frequency field: 0 off, 1 crystal/4, 2 crystal/8, 3 crystal/16.
// - Source power: 0 off, 1-2 min, 3-4 twice, 5-6 thrice, 7 four times.
// - Shutdown bit starts shutdown only while chip select is high; else stay active.
// - Receive enables, 1 on: converter, signal strength, IF filter, mixer, low noise amp.
// - Monitor enables: bit 1 temperature monitor, bit 0 supply monitor.
// - Converter result split: bits 7:2 in high[5:0], bits 1:0 in low[7:6].
// - Alarm when supply below 1.7 V plus 62 mV times code plus one.
// - Clock output is crystal divided by 4-bit value, reset 4; zero disables.
// - Supply alarm reported in interrupt source register 1, bit 7.
`ifndef RADIO_AUX_CONSTS_SVH
`define RADIO_AUX_CONSTS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_IMAGE_REJECT_CAL_SETUP 10'h319
`define IDX_CHIP_SHUTDOWN_REQUEST  10'h322
`define IDX_RECEIVE_CHAIN_POWER    10'h324
`define IDX_MONITOR_POWER          10'h325
`define IDX_CONVERTER_RESULT_HIGH  10'h327
`define IDX_CONVERTER_RESULT_LOW   10'h328
`define IDX_SUPPLY_ALARM_THRESHOLD 10'h32d
`define IDX_CLOCK_OUT_DIVIDER      10'h32e
`define IDX_INTERRUPT_SOURCE_1     10'h337

// ==========================================================================
// Field positions.
`define POS_OVERRIDE_EN   5
`define POS_SUPPLY_ALARM  7

// ==========================================================================
// Reset values.
`define RST_CAL_SETUP     6'h00
`define RST_RX_POWER      5'h00
`define RST_MON_POWER     2'h0
`define RST_TRIP_CODE     5'h00
`define RST_CLK_DIVIDER   4'h4

// ==========================================================================
// Supply trip level in millivolts.
`define TRIP_BASE_MV      13'd1700
`define TRIP_STEP_MV      13'd62

`endif

//--- verilog/radio_aux_control_regs.sv
// APB register bank for radio auxiliary control, readback and clock output.
`include "radio_aux_consts.svh"
`timescale 1ns/1ns
module radio_aux_control_regs #(
    parameter int CAL_W = 8
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [CAL_W-1:0]           auto_cal_result,
    input  wire logic [CAL_W-1:0]           user_cal_result,
    output logic      [CAL_W-1:0]           cal_result,
    output aux_types_pkg::cal_source_t      cal_source,
    output logic                            cal_source_clk,
    input  wire logic                       chip_select,
    output logic                            shutdown_start,
    output logic                            chip_active,
    output aux_types_pkg::rx_chain_en_t     rx_chain,
    output logic                            temp_monitor_on,
    output logic                            supply_monitor_on,
    input  wire logic [7:0]                 adc_result_in,
    input  wire logic                       adc_result_valid,
    input  wire logic [12:0]                supply_level_mv,
    input  wire logic                       supply_level_valid,
    output logic                            battery_alarm,
    output logic                            clock_out_pin,
    output logic                            clock_out_enable
);

    // ==========================================================================
    // Register state.
    logic [5:0]  cal_setup_r;
    logic        shutdown_request_r;
    logic [4:0]  rx_power_r;
    logic [1:0]  mon_power_r;
    logic [7:0]  adc_result_r;
    logic [4:0]  supply_trip_code_r;
    logic [3:0]  clk_divider_r;
    logic        alarm_flag_r;

    logic [5:0]  cal_setup_nxt;
    logic        shutdown_request_nxt;
    logic [4:0]  rx_power_nxt;
    logic [1:0]  mon_power_nxt;
    logic [7:0]  adc_result_nxt;
    logic [4:0]  supply_trip_code_nxt;
    logic [3:0]  clk_divider_nxt;
    logic        alarm_flag_nxt;

    // ==========================================================================
    // Bus decode.
    logic [9:0]  idx;
    logic        access;
    logic        wr_en;
    logic        hit_cal;
    logic        hit_shut;
    logic        hit_rx;
    logic        hit_mon;
    logic        hit_adc_hi;
    logic        hit_adc_lo;
    logic        hit_trip;
    logic        hit_div;
    logic        hit_irq1;
    logic        mapped;

    assign idx        = paddr[11:2];
    assign access     = psel && penable;
    assign wr_en      = access && pwrite;
    assign hit_cal    = (idx == `IDX_IMAGE_REJECT_CAL_SETUP);
    assign hit_shut   = (idx == `IDX_CHIP_SHUTDOWN_REQUEST);
    assign hit_rx     = (idx == `IDX_RECEIVE_CHAIN_POWER);
    assign hit_mon    = (idx == `IDX_MONITOR_POWER);
    assign hit_adc_hi = (idx == `IDX_CONVERTER_RESULT_HIGH);
    assign hit_adc_lo = (idx == `IDX_CONVERTER_RESULT_LOW);
    assign hit_trip   = (idx == `IDX_SUPPLY_ALARM_THRESHOLD);
    assign hit_div    = (idx == `IDX_CLOCK_OUT_DIVIDER);
    assign hit_irq1   = (idx == `IDX_INTERRUPT_SOURCE_1);
    assign mapped     = hit_cal | hit_shut | hit_rx | hit_mon | hit_adc_hi | hit_adc_lo
                      | hit_trip | hit_div | hit_irq1;

    // Zero wait states keep the slave simple; every access ends in its first access cycle.
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // ==========================================================================
    // Next values of the writable registers.
    // Reserved bits are not stored, so whatever software writes there is dropped.
    assign cal_setup_nxt        = (wr_en && hit_cal)  ? pwdata[5:0] : cal_setup_r;
    assign shutdown_request_nxt = (wr_en && hit_shut) ? pwdata[0]   : shutdown_request_r;
    assign rx_power_nxt         = (wr_en && hit_rx)   ? pwdata[4:0] : rx_power_r;
    assign mon_power_nxt        = (wr_en && hit_mon)  ? pwdata[1:0] : mon_power_r;
    assign supply_trip_code_nxt = (wr_en && hit_trip) ? pwdata[4:0] : supply_trip_code_r;
    assign clk_divider_nxt      = (wr_en && hit_div)  ? pwdata[3:0] : clk_divider_r;

    // ==========================================================================
    // Converter result capture.
    // The result is held until the converter delivers a new sample, so both halves
    // read back the same conversion unless a sample lands between the two reads.
    assign adc_result_nxt = adc_result_valid ? adc_result_in : adc_result_r;

    // ==========================================================================
    // Supply alarm flag.
    logic        trip_event;
    logic        alarm_clear;

    supply_trip_compare u_trip (
        .pclk         (pclk),
        .presetn      (presetn),
        .monitor_on   (mon_power_r[0]),
        .trip_code    (supply_trip_code_r),
        .supply_mv    (supply_level_mv),
        .supply_valid (supply_level_valid),
        .below_trip   (trip_event)
    );

    // Software clears the flag by writing one to its bit; a new trip in that cycle wins.
    assign alarm_clear    = wr_en && hit_irq1 && pwdata[`POS_SUPPLY_ALARM];
    assign alarm_flag_nxt = trip_event | (alarm_flag_r & ~alarm_clear);

    // ==========================================================================
    // Register update.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_setup_r        <= `RST_CAL_SETUP;
            shutdown_request_r <= 1'b0;
            rx_power_r         <= `RST_RX_POWER;
            mon_power_r        <= `RST_MON_POWER;
            adc_result_r       <= 8'h00;
            supply_trip_code_r <= `RST_TRIP_CODE;
            clk_divider_r      <= `RST_CLK_DIVIDER;
            alarm_flag_r       <= 1'b0;
        end
        else
        begin
            cal_setup_r        <= cal_setup_nxt;
            shutdown_request_r <= shutdown_request_nxt;
            rx_power_r         <= rx_power_nxt;
            mon_power_r        <= mon_power_nxt;
            adc_result_r       <= adc_result_nxt;
            supply_trip_code_r <= supply_trip_code_nxt;
            clk_divider_r      <= clk_divider_nxt;
            alarm_flag_r       <= alarm_flag_nxt;
        end
    end

    // ==========================================================================
    // Read data.
    logic [7:0]  rd_byte;
    logic [7:0]  rd_cal;
    logic [7:0]  rd_shut;
    logic [7:0]  rd_rx;
    logic [7:0]  rd_mon;
    logic [7:0]  rd_adc_hi;
    logic [7:0]  rd_adc_lo;
    logic [7:0]  rd_trip;
    logic [7:0]  rd_div;
    logic [7:0]  rd_irq1;

    assign rd_cal    = hit_cal    ? {2'b00, cal_setup_r}          : 8'h00;
    assign rd_shut   = hit_shut   ? {7'h00, shutdown_request_r}   : 8'h00;
    assign rd_rx     = hit_rx     ? {3'b000, rx_power_r}          : 8'h00;
    assign rd_mon    = hit_mon    ? {6'h00, mon_power_r}          : 8'h00;
    assign rd_adc_hi = hit_adc_hi ? {2'b00, adc_result_r[7:2]}    : 8'h00;
    assign rd_adc_lo = hit_adc_lo ? {adc_result_r[1:0], 6'h00}    : 8'h00;
    assign rd_trip   = hit_trip   ? {3'b000, supply_trip_code_r}  : 8'h00;
    assign rd_div    = hit_div    ? {4'h0, clk_divider_r}         : 8'h00;
    assign rd_irq1   = hit_irq1   ? {alarm_flag_r, 7'h00}         : 8'h00;
    assign rd_byte   = rd_cal | rd_shut | rd_rx | rd_mon | rd_adc_hi | rd_adc_lo
                     | rd_trip | rd_div | rd_irq1;
    assign prdata    = (access && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    // ==========================================================================
    // Calibration source and result selection.
    logic [2:0]  level_nxt;
    logic [4:0]  cal_ratio;
    logic        cal_clk_on;
    logic [CAL_W-1:0] cal_result_nxt;

    assign cal_result_nxt = cal_setup_r[`POS_OVERRIDE_EN] ? user_cal_result : auto_cal_result;

    assign cal_ratio = (cal_setup_r[4:3] == 2'd1) ? 5'd4  :
                       (cal_setup_r[4:3] == 2'd2) ? 5'd8  :
                       (cal_setup_r[4:3] == 2'd3) ? 5'd16 : 5'd0;

    assign level_nxt = 3'(({1'b0, cal_setup_r[2:0]} + 4'd1) >> 1);

    ratio_clock_divider #(
        .W (5)
    ) u_cal_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .ratio      (cal_ratio),
        .clk_out    (cal_source_clk),
        .clk_active (cal_clk_on)
    );

    // ==========================================================================
    // Clock output.
    // Clock output divider
    ratio_clock_divider #(
        .W (4)
    ) u_out_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .ratio      (clk_divider_r),
        .clk_out    (clock_out_pin),
        .clk_active (clock_out_enable)
    );

    // ==========================================================================
    // Registered control outputs.
    // Shutdown gated by chip select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shutdown_start <= 1'b0;
            chip_active    <= 1'b1;
        end
        else
        begin
            shutdown_start <= shutdown_request_r && chip_select;
            chip_active    <= !(shutdown_request_r && chip_select);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_result        <= '0;
            cal_source        <= '0;
            rx_chain          <= '0;
            temp_monitor_on   <= 1'b0;
            supply_monitor_on <= 1'b0;
            battery_alarm     <= 1'b0;
        end
        else
        begin
            cal_result           <= cal_result_nxt;
            cal_source.freq_sel  <= cal_setup_r[4:3];
            cal_source.power_sel <= cal_setup_r[2:0];
            cal_source.source_on <= cal_clk_on && (cal_setup_r[2:0] != 3'd0);
            cal_source.level     <= level_nxt;
            rx_chain             <= rx_power_r;
            temp_monitor_on      <= mon_power_r[1];
            supply_monitor_on    <= mon_power_r[0];
            battery_alarm        <= alarm_flag_nxt;
        end
    end

endmodule

//--- verilog/ratio_clock_divider.sv
// Divides the system clock by a programmable ratio; a ratio of zero holds the output low.
`timescale 1ns/1ns
module ratio_clock_divider #(
    parameter int W = 5
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] ratio,
    output logic              clk_out,
    output logic              clk_active
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic [W-1:0] half;
    logic         wrap;
    logic         out_nxt;

    // ==========================================================================
    // Counter and waveform.
    // Ratio one cannot be shown by a flop, so it reads as a steady high level.
    assign half    = W'(({1'b0, ratio} + (W+1)'(1)) >> 1);
    assign wrap    = (cnt_r >= ratio - W'(1));
    assign cnt_nxt = (ratio == '0 || wrap) ? '0 : cnt_r + W'(1);
    assign out_nxt = (ratio != '0) && (cnt_nxt < half);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r      <= '0;
            clk_out    <= 1'b0;
            clk_active <= 1'b0;
        end
        else
        begin
            cnt_r      <= cnt_nxt;
            clk_out    <= out_nxt;
            clk_active <= (ratio != '0);
        end
    end

endmodule

//--- verilog/supply_trip_compare.sv
// Compares a supply sample against the programmed trip level and pulses on a low reading.
`include "radio_aux_consts.svh"
`timescale 1ns/1ns
module supply_trip_compare (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        monitor_on,
    input  wire logic [4:0]  trip_code,
    input  wire logic [12:0] supply_mv,
    input  wire logic        supply_valid,
    output logic             below_trip
);

    logic [12:0] trip_mv;
    logic [12:0] code_plus_one;

    // ==========================================================================
    // Trip level.
    // Trip level formula
    assign code_plus_one = {8'h00, trip_code} + 13'd1;
    assign trip_mv       = 13'(`TRIP_BASE_MV + `TRIP_STEP_MV * code_plus_one);

    // Only a fresh sample taken while the monitor is enabled can raise the alarm.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            below_trip <= 1'b0;
        else
            below_trip <= monitor_on && supply_valid && (supply_mv < trip_mv);
    end

endmodule
